// ==== core/cpsm_defs.svh ====
/*
 * Offsets, field positions and reset values for the
 * control pin / serial port mux. Assumes a 32-bit AHB-Lite map.
 */
`ifndef CPSM_DEFS_SVH
`define CPSM_DEFS_SVH

`define CPSM_GCR_OFS      12'h000
`define CPSM_STAT_OFS     12'h004
`define CPSM_ADDR_W       12
`define CPSM_SPSB_POS     0
`define CPSM_SPSB_RST     1'b0
`define CPSM_ST_SER_POS   0
`define CPSM_ST_SEL_LSB   1
`define CPSM_ST_SEL_MSB   3
`define CPSM_ST_FORCE_POS 4
`define CPSM_SEL_RST      3'h0

`endif

// ==== core/cpsm_pkg.sv ====
/*
 * Types shared by the control pin / serial port mux.
 * Assumes cpsm_defs.svh supplies the numeric constants.
 */
package cpsm_pkg;

    typedef logic [2:0] cpsm_sel_t;

    // Synchronised pin levels seen by the link-side logic
    typedef struct packed {
        logic pin2;
        logic pin1;
        logic pin0;
        logic core_ok;
        logic out_gnd;
    } cpsm_pins_s;

    // Mux state reported back to the bus side
    typedef struct packed {
        logic      forced;
        cpsm_sel_t sel;
        logic      serial_en;
    } cpsm_stat_s;

endpackage

// ==== core/cpsm_top.sv ====
/*
 * Control pin / serial port mux with an AHB-Lite register slave.
 * Assumes a free-running link_clk and open-drain pads resolved outside.
 */
// The placing of the registers and the AHB-Lite slave port are this design's own decisions.
// Function
// - Select bit at 0 enables the two-wire serial port on shared pins
// - Serial mode: select pin 1 carries SDA, select pin 2 carries SCL
// - Serial mode: setup bits 2 and 1 read zero, pin 0 picks 000/001
// - Select bit at 1: serial off, pins 2..0 pick one of eight setups
// - Select bit lives in the generic control register, software writable
// - Core supply up and output supply grounded forces serial mode
`timescale 1ns/1ps
`default_nettype none
`include "cpsm_defs.svh"

module cpsm_top (
    input  wire logic              hclk,
    input  wire logic              hresetn,
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic [31:0]            hrdata,
    output logic                   hreadyout,
    output logic                   hresp,
    input  wire logic              link_clk,
    input  wire logic              setup_select_pin0_in,
    input  wire logic              setup_select_pin1_in,
    output logic                   setup_select_pin1_out,
    output logic                   setup_select_pin1_oe,
    input  wire logic              setup_select_pin2_in,
    output logic                   setup_select_pin2_out,
    output logic                   setup_select_pin2_oe,
    input  wire logic              core_supply_ok,
    input  wire logic              out_supply_gnd,
    input  wire logic              ser_sda_pull,
    input  wire logic              ser_scl_pull,
    output logic                   ser_enable,
    output logic                   ser_sda_in,
    output logic                   ser_scl_in,
    output cpsm_pkg::cpsm_sel_t    setup_sel
);
    import cpsm_pkg::*;

    // Bus side
    logic                    ap_wr_q;
    logic                    ap_sel_gcr_q;
    logic                    gcr_spsb_q;
    logic [31:0]             rdata_d;
    logic                    take;
    logic [`CPSM_ADDR_W-1:0] aoff;
    cpsm_stat_s              stat_h_q;
    logic                    req_h1_q;
    logic                    req_h2_q;
    logic                    ack_h_q;

    // Link side
    logic                    lrst1_q;
    logic                    lrst_n_q;
    cpsm_pins_s              pins_raw;
    cpsm_pins_s              pins1_q;
    cpsm_pins_s              pins_s_q;
    logic                    spsb1_q;
    logic                    spsb_s_q;
    logic                    force_l;
    logic                    serial_en_d;
    cpsm_sel_t               sel_d;
    logic                    serial_en_q;
    cpsm_sel_t               sel_q;
    logic                    force_q;
    cpsm_stat_s              stat_l;
    cpsm_stat_s              stat_hold_q;
    logic                    req_l_q;
    logic                    ack_l1_q;
    logic                    ack_l2_q;

    assign take = hsel && hready && htrans[1];
    assign aoff = haddr[`CPSM_ADDR_W-1:0];

    // Single-cycle slave: never stalls, never errors
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // Address phase capture for writes
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ap_wr_q      <= 1'b0;
            ap_sel_gcr_q <= 1'b0;
        end
        else if (hready)
        begin
            ap_wr_q      <= take && hwrite;
            ap_sel_gcr_q <= (aoff == `CPSM_GCR_OFS);
        end
    end

    // Generic control register: select bit written in data phase
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            gcr_spsb_q <= `CPSM_SPSB_RST;
        else if (ap_wr_q && ap_sel_gcr_q)
            gcr_spsb_q <= hwdata[`CPSM_SPSB_POS];
    end

    // Read mux; unmapped words read zero
    always_comb
    begin
        rdata_d = 32'h0000_0000;
        case (aoff)
            `CPSM_GCR_OFS:
                rdata_d[`CPSM_SPSB_POS] = gcr_spsb_q;
            `CPSM_STAT_OFS:
            begin
                rdata_d[`CPSM_ST_SER_POS] = stat_h_q.serial_en;
                rdata_d[`CPSM_ST_SEL_MSB:`CPSM_ST_SEL_LSB] = stat_h_q.sel;
                rdata_d[`CPSM_ST_FORCE_POS] = stat_h_q.forced;
            end
            default:
                rdata_d = 32'h0000_0000;
        endcase
    end

    // Read data registered at the address phase edge
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata <= 32'h0000_0000;
        else if (take && !hwrite)
            hrdata <= rdata_d;
    end

    // Status words arrive by req/ack handshake from the link side
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            req_h1_q <= 1'b0;
            req_h2_q <= 1'b0;
        end
        else
        begin
            req_h1_q <= req_l_q;
            req_h2_q <= req_h1_q;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ack_h_q  <= 1'b0;
            stat_h_q <= '0;
        end
        else if (req_h2_q != ack_h_q)
        begin
            // Hold word is frozen while req differs from ack
            ack_h_q  <= req_h2_q;
            stat_h_q <= stat_hold_q;
        end
    end

    // Link reset: asserted at once, released on link_clk
    always_ff @(posedge link_clk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            lrst1_q  <= 1'b0;
            lrst_n_q <= 1'b0;
        end
        else
        begin
            lrst1_q  <= 1'b1;
            lrst_n_q <= lrst1_q;
        end
    end

    assign pins_raw = '{pin2:    setup_select_pin2_in,
                        pin1:    setup_select_pin1_in,
                        pin0:    setup_select_pin0_in,
                        core_ok: core_supply_ok,
                        out_gnd: out_supply_gnd};

    // Pads and supply sense are asynchronous: two flops each
    always_ff @(posedge link_clk or negedge lrst_n_q)
    begin
        if (!lrst_n_q)
        begin
            pins1_q  <= '0;
            pins_s_q <= '0;
        end
        else
        begin
            pins1_q  <= pins_raw;
            pins_s_q <= pins1_q;
        end
    end

    // Select bit crosses as a level
    always_ff @(posedge link_clk or negedge lrst_n_q)
    begin
        if (!lrst_n_q)
        begin
            spsb1_q  <= `CPSM_SPSB_RST;
            spsb_s_q <= `CPSM_SPSB_RST;
        end
        else
        begin
            spsb1_q  <= gcr_spsb_q;
            spsb_s_q <= spsb1_q;
        end
    end

    // Grounded output supply keeps reprogramming possible
    assign force_l = pins_s_q.core_ok && pins_s_q.out_gnd;

    always_comb
    begin
        serial_en_d = !spsb_s_q || force_l;
        if (serial_en_d)
            sel_d = {2'b00, pins_s_q.pin0};
        else
            sel_d = {pins_s_q.pin2, pins_s_q.pin1, pins_s_q.pin0};
    end

    always_ff @(posedge link_clk or negedge lrst_n_q)
    begin
        if (!lrst_n_q)
        begin
            serial_en_q <= 1'b0;
            sel_q       <= `CPSM_SEL_RST;
            force_q     <= 1'b0;
        end
        else
        begin
            serial_en_q <= serial_en_d;
            sel_q       <= sel_d;
            force_q     <= force_l;
        end
    end

    // Serial lines go to the engine only in serial mode
    always_ff @(posedge link_clk or negedge lrst_n_q)
    begin
        if (!lrst_n_q)
        begin
            ser_sda_in <= 1'b1;
            ser_scl_in <= 1'b1;
        end
        else if (serial_en_d)
        begin
            ser_sda_in <= pins_s_q.pin1;
            ser_scl_in <= pins_s_q.pin2;
        end
        else
        begin
            // Idle bus level so the engine sees no traffic
            ser_sda_in <= 1'b1;
            ser_scl_in <= 1'b1;
        end
    end

    // Open-drain drive: low only while serial mode owns the pin
    always_ff @(posedge link_clk or negedge lrst_n_q)
    begin
        if (!lrst_n_q)
        begin
            setup_select_pin1_oe  <= 1'b0;
            setup_select_pin2_oe  <= 1'b0;
            setup_select_pin1_out <= 1'b0;
            setup_select_pin2_out <= 1'b0;
        end
        else
        begin
            setup_select_pin1_oe  <= serial_en_d && ser_sda_pull;
            setup_select_pin2_oe  <= serial_en_d && ser_scl_pull;
            setup_select_pin1_out <= 1'b0;
            setup_select_pin2_out <= 1'b0;
        end
    end

    assign ser_enable = serial_en_q;
    assign setup_sel  = sel_q;

    // Status handshake, link end
    assign stat_l = '{forced: force_q, sel: sel_q, serial_en: serial_en_q};

    always_ff @(posedge link_clk or negedge lrst_n_q)
    begin
        if (!lrst_n_q)
        begin
            ack_l1_q <= 1'b0;
            ack_l2_q <= 1'b0;
        end
        else
        begin
            ack_l1_q <= ack_h_q;
            ack_l2_q <= ack_l1_q;
        end
    end

    always_ff @(posedge link_clk or negedge lrst_n_q)
    begin
        if (!lrst_n_q)
        begin
            req_l_q     <= 1'b0;
            stat_hold_q <= '0;
        end
        else if ((req_l_q == ack_l2_q) && (stat_l != stat_hold_q))
        begin
            req_l_q     <= !req_l_q;
            stat_hold_q <= stat_l;
        end
    end

    // Checks
    select_zero_a: assert property (
        @(posedge link_clk) disable iff (!lrst_n_q)
        !spsb_s_q |=> ser_enable)
        else $error("serial port not enabled with select bit at 0");

    pin_roles_a: assert property (
        @(posedge link_clk) disable iff (!lrst_n_q)
        serial_en_d |=> (ser_sda_in == $past(pins_s_q.pin1))
                     && (ser_scl_in == $past(pins_s_q.pin2)))
        else $error("serial lines not taken from pins 1 and 2");

    serial_sel_a: assert property (
        @(posedge link_clk) disable iff (!lrst_n_q)
        serial_en_d |=> setup_sel == {2'b00, $past(pins_s_q.pin0)})
        else $error("setup selection wrong in serial mode");

    pin_mode_a: assert property (
        @(posedge link_clk) disable iff (!lrst_n_q)
        (spsb_s_q && !force_l) |=> !ser_enable
            && setup_sel == $past({pins_s_q.pin2, pins_s_q.pin1,
                                   pins_s_q.pin0}))
        else $error("control pin mode not honoured");

    pin_quiet_a: assert property (
        @(posedge link_clk) disable iff (!lrst_n_q)
        !serial_en_d |=> !setup_select_pin1_oe && !setup_select_pin2_oe
                         && ser_sda_in && ser_scl_in)
        else $error("shared pins driven in control pin mode");

    gcr_write_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (ap_wr_q && ap_sel_gcr_q) |=> gcr_spsb_q == $past(hwdata[0]))
        else $error("select bit not written");

    gcr_reach_a: assert property (
        @(posedge link_clk) disable iff (!lrst_n_q)
        $changed(spsb1_q) |=> spsb_s_q == $past(spsb1_q))
        else $error("select bit not carried to link side");

    force_serial_a: assert property (
        @(posedge link_clk) disable iff (!lrst_n_q)
        (pins_s_q.core_ok && pins_s_q.out_gnd) |=> ser_enable ##0 force_q)
        else $error("grounded output supply did not force serial mode");

    serial_mode_c: cover property (
        @(posedge link_clk) disable iff (!lrst_n_q)
        !spsb_s_q ##1 ser_enable && setup_sel == 3'h1);

    pin_mode_c: cover property (
        @(posedge link_clk) disable iff (!lrst_n_q)
        !ser_enable && setup_sel == 3'h7);

    forced_c: cover property (
        @(posedge link_clk) disable iff (!lrst_n_q)
        spsb_s_q && force_l ##1 ser_enable);

endmodule
`default_nettype wire

// ==== verification/control_pin_serial_mux_tb.sv ====
/*
 * Self-checking bench for the control pin / serial port mux.
 * Assumes a zero-wait AHB-Lite slave and a free-running link clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "cpsm_defs.svh"

module control_pin_serial_mux_tb;
    import cpsm_pkg::*;

    logic        hclk     = 1'b0;
    logic        link_clk = 1'b0;
    logic        hresetn  = 1'b0;
    logic        hsel     = 1'b0;
    logic        hwrite   = 1'b0;
    logic [31:0] haddr    = 32'h0;
    logic [31:0] hwdata   = 32'h0;
    logic [1:0]  htrans   = 2'h0;
    logic [2:0]  hsize    = 3'h2;
    logic [2:0]  jmp      = 3'h7;
    logic        hsda     = 1'b0;
    logic        hscl     = 1'b0;
    logic        psda     = 1'b0;
    logic        pscl     = 1'b0;
    logic        cok      = 1'b0;
    logic        ognd     = 1'b0;
    logic [31:0] rd;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        p0;
    logic        p1;
    logic        p2;
    logic        oe1;
    logic        oe2;
    logic        po1;
    logic        po2;
    logic        sen;
    logic        sdi;
    logic        scli;
    cpsm_sel_t   sel;
    int          fail_count = 0;
    int          cmp_count  = 0;

    always #25 hclk = ~hclk;

    // Offset start keeps the two clocks out of step
    initial
    begin
        #7;
        forever #40 link_clk = ~link_clk;
    end

    cpsm_top dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .link_clk(link_clk), .setup_select_pin0_in(p0),
        .setup_select_pin1_in(p1), .setup_select_pin1_out(po1),
        .setup_select_pin1_oe(oe1), .setup_select_pin2_in(p2),
        .setup_select_pin2_out(po2), .setup_select_pin2_oe(oe2),
        .core_supply_ok(cok), .out_supply_gnd(ognd),
        .ser_sda_pull(psda), .ser_scl_pull(pscl), .ser_enable(sen),
        .ser_sda_in(sdi), .ser_scl_in(scli), .setup_sel(sel)
    );

    cpsm_pin_model far (
        .jump0(jmp[0]), .jump1(jmp[1]), .jump2(jmp[2]),
        .host_sda_low(hsda), .host_scl_low(hscl),
        .dut_oe1(oe1), .dut_oe2(oe2), .dut_out1(po1), .dut_out2(po2),
        .pin0(p0), .pin1(p1), .pin2(p2)
    );

    task chk(input string what, input logic [31:0] exp,
             input logic [31:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("unexpected %s: expected %0h, seen %0h", what, exp, got);
        end
    endtask

    // Single word transfer; waits for hready in both phases
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] wd);
        hsel   <= 1'b1;
        haddr  <= {20'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
        chk("hresp", 32'h0, {31'h0, hresp});
    endtask

    // Long enough for the sync stages and the status handshake
    task settle;
        repeat (10) @(posedge link_clk);
        @(posedge hclk);
    endtask

    task mode(input logic en, input logic [2:0] s, input logic f);
        settle;
        chk("ser_enable", {31'h0, en}, {31'h0, sen});
        chk("setup_sel", {29'h0, s}, {29'h0, sel});
        xfer(1'b0, `CPSM_STAT_OFS, 32'h0);
        chk("status", {27'h0, f, s, en}, rd);
    endtask

    task stop_test;
        $display("compares %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial
    begin
        repeat (3000) @(posedge hclk);
        fail_count++;
        $display("unexpected watchdog expiry");
        stop_test;
    end

    initial
    begin
        // Link flops reset on the first link edge inside this window
        repeat (3) @(posedge hclk);
        chk("hreadyout", 32'h1, {31'h0, hreadyout});
        chk("reset_link", 32'h3, {24'h0, sen, sel, oe2, oe1, scli, sdi});
        hresetn <= 1'b1;
        @(posedge hclk);
        xfer(1'b0, `CPSM_GCR_OFS, 32'h0);
        chk("gcr", 32'h0, rd);
        $display("reset test done");
        mode(1'b1, 3'h1, 1'b0);
        jmp <= 3'h6;
        mode(1'b1, 3'h0, 1'b0);
        jmp <= 3'h7;
        hsda <= 1'b1;
        settle;
        chk("sda_scl_in", 32'h2, {30'h0, scli, sdi});
        hsda <= 1'b0;
        hscl <= 1'b1;
        settle;
        chk("sda_scl_in", 32'h1, {30'h0, scli, sdi});
        hscl <= 1'b0;
        for (int k = 1; k < 3; k++)
        begin
            {pscl, psda} <= k[1:0];
            settle;
            chk("pin_oe", k, {30'h0, oe2, oe1});
            chk("pin_out", 32'h0, {30'h0, po2, po1});
        end
        $display("serial mode test done");
        xfer(1'b1, `CPSM_GCR_OFS, 32'h1);
        xfer(1'b0, `CPSM_GCR_OFS, 32'h0);
        chk("gcr", 32'h1, rd);
        {pscl, psda} <= 2'h3;
        for (int i = 0; i < 8; i++)
        begin
            jmp <= i[2:0];
            mode(1'b0, i[2:0], 1'b0);
            chk("pin_oe", 32'h0, {30'h0, oe2, oe1});
            chk("sda_scl_in", 32'h3, {30'h0, scli, sdi});
        end
        $display("pin mode test done");
        cok  <= 1'b1;
        ognd <= 1'b1;
        jmp  <= 3'h7;
        mode(1'b1, 3'h1, 1'b1);
        chk("pin_oe", 32'h3, {30'h0, oe2, oe1});
        cok <= 1'b0;
        mode(1'b0, 3'h7, 1'b0);
        cok  <= 1'b1;
        ognd <= 1'b0;
        mode(1'b0, 3'h7, 1'b0);
        $display("forced serial test done");
        xfer(1'b1, 12'h008, 32'h0);
        xfer(1'b0, 12'h008, 32'h0);
        chk("unmapped", 32'h0, rd);
        xfer(1'b0, `CPSM_GCR_OFS, 32'h0);
        chk("gcr", 32'h1, rd);
        $display("unmapped access test done");
        stop_test;
    end
endmodule

`default_nettype wire

// ==== verification/cpsm_pin_model.sv ====
/*
 * Far side of the shared pins: jumper levels and a two-wire host.
 * Assumes pull-ups on pins 1 and 2 and open-drain drivers on both sides.
 */
`timescale 1ns/1ps
`default_nettype none

module cpsm_pin_model (
    input  wire logic jump0,
    input  wire logic jump1,
    input  wire logic jump2,
    input  wire logic host_sda_low,
    input  wire logic host_scl_low,
    input  wire logic dut_oe1,
    input  wire logic dut_oe2,
    input  wire logic dut_out1,
    input  wire logic dut_out2,
    output logic      pin0,
    output logic      pin1,
    output logic      pin2
);
    // Wired-AND: any party pulling low beats the pull-up
    assign pin0 = jump0;
    // Enabled driver only sinks; a high out never wins over the pull-up
    assign pin1 = jump1 & ~host_sda_low & ~(dut_oe1 & ~dut_out1);
    assign pin2 = jump2 & ~host_scl_low & ~(dut_oe2 & ~dut_out2);
endmodule

`default_nettype wire
